// file: rtl/vic_pkg.sv
`default_nettype none
package vic_pkg;
  // Line and slot counts
  localparam int NUM_LINES = 32;
  localparam int NUM_SLOTS = 16;
  localparam int ADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] OFS_NORM_STATUS = 12'h000;
  localparam logic [11:0] OFS_FAST_STATUS = 12'h004;
  localparam logic [11:0] OFS_RAW_STATUS = 12'h008;
  localparam logic [11:0] OFS_LINE_SELECT = 12'h00C;
  localparam logic [11:0] OFS_LINE_ENABLE = 12'h010;
  localparam logic [11:0] OFS_VECT_NOW = 12'h014;
  localparam logic [11:0] OFS_DEF_VECT = 12'h018;
  localparam logic [11:0] OFS_EV_STATUS = 12'h01C;
  localparam logic [11:0] OFS_EV_MASK = 12'h020;
  // Slot banks: page in bits 11:8, slot index in bits 5:2
  localparam logic [3:0] PAGE_SLOT_ADDR = 4'h1;
  localparam logic [3:0] PAGE_SLOT_CTRL = 4'h2;

  // Slot control fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_SRC_W = 5;
  localparam int CTRL_EN_BIT = 5;

  // Event status bits
  localparam int EV_W = 3;
  localparam int EV_FAST_ROSE = 0;
  localparam int EV_NORM_ROSE = 1;
  localparam int EV_CHAIN_ROSE = 2;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [EV_W-1:0] RST_EV = 3'h0;

  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // Request and vector passed along a chain
  typedef struct packed {
    logic req;
    logic [31:0] vect;
  } chain_t;
endpackage
`default_nettype wire

// file: rtl/vic_core.sv
`default_nettype none
module vic_core
  import vic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // Request lines from peripherals
  input wire logic [NUM_LINES-1:0] irq_lines,
  // From a downstream instance
  input wire chain_t chain_in,
  // To the core, or to an upstream instance
  output logic fast_interrupt_request,
  output logic normal_interrupt_request,
  output logic [31:0] vector_address,
  output logic event_irq
);

  typedef struct packed {
    logic [NUM_LINES-1:0] sync1;
    logic [NUM_LINES-1:0] sync2;
    logic [NUM_LINES-1:0] select;
    logic [NUM_LINES-1:0] enable;
    logic [31:0] def_vect;
    logic [NUM_SLOTS-1:0][31:0] slot_addr;
    logic [NUM_SLOTS-1:0] slot_en;
    logic [NUM_SLOTS-1:0][CTRL_SRC_W-1:0] slot_src;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic prev_fast;
    logic prev_norm;
    logic prev_chain;
    logic fast_req;
    logic norm_req;
    logic [31:0] vect;
    logic ev_irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s_ff;
  state_t nxt_s;
  logic [NUM_LINES-1:0] fast_m;
  logic [NUM_LINES-1:0] norm_m;
  logic [NUM_SLOTS-1:0] slot_hit;

  // Register decode, shared by read and write paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [3:0] pg;
    pg = a[11:8];
    if (a[1:0] != 2'h0) begin
      return 1'b0;
    end
    if ((pg == PAGE_SLOT_ADDR || pg == PAGE_SLOT_CTRL) && a[7:6] == 2'h0) begin
      return 1'b1;
    end
    return (a <= OFS_EV_MASK);
  endfunction

  function automatic logic [31:0] read_word(input state_t s, input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    logic [3:0] idx;
    w = RST_WORD;
    idx = a[5:2];
    if (a[11:8] == PAGE_SLOT_ADDR) begin
      w = s.slot_addr[idx];
    end else if (a[11:8] == PAGE_SLOT_CTRL) begin
      w[CTRL_SRC_LSB +: CTRL_SRC_W] = s.slot_src[idx];
      w[CTRL_EN_BIT] = s.slot_en[idx];
    end else begin
      case (a)
        OFS_NORM_STATUS: w = s.sync2 & s.enable & ~s.select;
        OFS_FAST_STATUS: w = s.sync2 & s.enable & s.select;
        OFS_RAW_STATUS: w = s.sync2;
        OFS_LINE_SELECT: w = s.select;
        OFS_LINE_ENABLE: w = s.enable;
        OFS_VECT_NOW: w = s.vect;
        OFS_DEF_VECT: w = s.def_vect;
        OFS_EV_STATUS: w[EV_W-1:0] = s.ev_status;
        OFS_EV_MASK: w[EV_W-1:0] = s.ev_mask;
        default: w = RST_WORD;
      endcase
    end
    return w;
  endfunction

  // Next-state logic
  always_comb begin
    logic access;
    logic done;
    logic wr;
    logic rd_ev;
    logic found;
    logic [3:0] widx;
    logic [EV_W-1:0] ev_set;
    access = 1'b0;
    done = 1'b0;
    wr = 1'b0;
    rd_ev = 1'b0;
    found = 1'b0;
    widx = 4'h0;
    ev_set = RST_EV;
    nxt_s = s_ff;
    slot_hit = '0;

    // Pins pass two flops before use
    nxt_s.sync1 = irq_lines;
    nxt_s.sync2 = s_ff.sync1;

    // Masking, then split onto the two paths
    fast_m = s_ff.sync2 & s_ff.enable & s_ff.select;
    norm_m = s_ff.sync2 & s_ff.enable & ~s_ff.select;

    // Slots only look at normal requests
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slot_hit[i] = s_ff.slot_en[i] & norm_m[s_ff.slot_src[i]];
    end

    // Request outputs; a downstream request merges into the normal path
    nxt_s.fast_req = |fast_m;
    nxt_s.norm_req = (|norm_m) | chain_in.req;

    // Vector pick: lowest hit slot first, then default for own lines, then chained, else default
    nxt_s.vect = s_ff.def_vect;
    if (chain_in.req) begin
      nxt_s.vect = chain_in.vect;
    end
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (slot_hit[i]) begin
        nxt_s.vect = s_ff.slot_addr[i];
        found = 1'b1;
      end
    end
    // Own non-vectored lines outrank the chain when no slot hits
    if (!found && (|norm_m)) begin
      nxt_s.vect = s_ff.def_vect;
    end

    // Event edges
    nxt_s.prev_fast = s_ff.fast_req;
    nxt_s.prev_norm = s_ff.norm_req;
    nxt_s.prev_chain = chain_in.req;
    ev_set[EV_FAST_ROSE] = s_ff.fast_req & ~s_ff.prev_fast;
    ev_set[EV_NORM_ROSE] = s_ff.norm_req & ~s_ff.prev_norm;
    ev_set[EV_CHAIN_ROSE] = chain_in.req & ~s_ff.prev_chain;

    // APB: one wait state, then completion
    access = apb_req.psel & apb_req.penable;
    done = access & s_ff.pready;
    nxt_s.pready = access & ~s_ff.pready;
    nxt_s.pslverr = 1'b0;
    if (access && !s_ff.pready) begin
      nxt_s.prdata = apb_req.pwrite ? RST_WORD : read_word(s_ff, apb_req.paddr);
      nxt_s.pslverr = ~is_mapped(apb_req.paddr);
    end
    wr = done & apb_req.pwrite & is_mapped(apb_req.paddr);
    rd_ev = done & ~apb_req.pwrite & (apb_req.paddr == OFS_EV_STATUS);
    widx = apb_req.paddr[5:2];

    // Register writes
    if (wr) begin
      if (apb_req.paddr[11:8] == PAGE_SLOT_ADDR) begin
        nxt_s.slot_addr[widx] = apb_req.pwdata;
      end else if (apb_req.paddr[11:8] == PAGE_SLOT_CTRL) begin
        nxt_s.slot_src[widx] = apb_req.pwdata[CTRL_SRC_LSB +: CTRL_SRC_W];
        nxt_s.slot_en[widx] = apb_req.pwdata[CTRL_EN_BIT];
      end else begin
        case (apb_req.paddr)
          OFS_LINE_SELECT: nxt_s.select = apb_req.pwdata;
          OFS_LINE_ENABLE: nxt_s.enable = apb_req.pwdata;
          OFS_DEF_VECT: nxt_s.def_vect = apb_req.pwdata;
          OFS_EV_MASK: nxt_s.ev_mask = apb_req.pwdata[EV_W-1:0];
          default: nxt_s.ev_mask = s_ff.ev_mask;
        endcase
      end
    end

    // Read clears only the bits it returned, so an event landing mid-transfer survives
    nxt_s.ev_status = (s_ff.ev_status & ~(rd_ev ? s_ff.prdata[EV_W-1:0] : RST_EV)) | ev_set;
    nxt_s.ev_irq = |(nxt_s.ev_status & nxt_s.ev_mask);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from flops
  assign fast_interrupt_request = s_ff.fast_req;
  assign normal_interrupt_request = s_ff.norm_req;
  assign vector_address = s_ff.vect;
  assign event_irq = s_ff.ev_irq;
  assign apb_rsp = '{pready: s_ff.pready, pslverr: s_ff.pslverr, prdata: s_ff.prdata};

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_fast_follow: assert property ((|fast_m) |=> fast_interrupt_request)
    else $error("fast request missing");
  a_fast_drop: assert property ((fast_m == '0) |=> !fast_interrupt_request)
    else $error("fast request without a fast line");
  a_norm_follow: assert property ((|norm_m) |=> normal_interrupt_request)
    else $error("normal request missing");
  a_slot_zero_wins: assert property (slot_hit[0] |=> vector_address == $past(s_ff.slot_addr[0]))
    else $error("slot 0 not chosen");
  a_slot_vector: assert property (slot_hit[1] && !slot_hit[0] |=> vector_address == $past(s_ff.slot_addr[1]))
    else $error("wrong slot vector");
  a_default_vector: assert property ((|norm_m) && slot_hit == '0 |=> vector_address == $past(s_ff.def_vect))
    else $error("default vector not shown");
  a_chain_pass: assert property (chain_in.req && norm_m == '0 ##1 chain_in.req |->
    normal_interrupt_request && vector_address == $past(chain_in.vect))
    else $error("chained request lost");
  a_mask_blocks: assert property (s_ff.enable == '0 && !chain_in.req |=> !fast_interrupt_request
    && !normal_interrupt_request)
    else $error("masked line reached core");
  a_raw_read: assert property (apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == OFS_RAW_STATUS
    |-> apb_rsp.prdata == $past(s_ff.sync2))
    else $error("raw status read wrong");
  a_slot_write: assert property (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
    && apb_req.paddr == {PAGE_SLOT_ADDR, 8'h04} |=> s_ff.slot_addr[1] == $past(apb_req.pwdata))
    else $error("slot address not stored");
  a_pin_delay: assert property ($rose(irq_lines[0]) |-> ##1 !s_ff.sync2[0] ##1 s_ff.sync2[0])
    else $error("line sync delay wrong");
  a_apb_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("bus answer late");

  c_fast: cover property (fast_interrupt_request && normal_interrupt_request);
  c_two_slots: cover property (slot_hit[0] && slot_hit[15]);
  c_chain: cover property (chain_in.req && normal_interrupt_request && norm_m == '0);
  c_event_irq: cover property ($rose(event_irq));

endmodule
`default_nettype wire

// file: sim/irq_source_model.sv
`default_nettype none
module irq_source_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raise and service masks, one cycle each
  input wire logic [31:0] raise,
  input wire logic [31:0] service,
  // Level request lines
  output logic [31:0] irq_lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // A line stays high until its routine services it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_lines <= 32'h0;
    end else begin
      irq_lines <= (irq_lines & ~service) | raise;
    end
  end
endmodule
`default_nettype wire

// file: sim/vectored_interrupt_controller_tb_top.sv
`default_nettype none
module vectored_interrupt_controller_tb_top
  import vic_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] lines;
    logic ch;
    logic f;
    logic n;
    logic [31:0] v;
  } row_t;
  localparam logic [31:0] SEL = 32'h8000_0000;
  localparam logic [31:0] DEF = 32'h0000_0D00;
  localparam logic [31:0] CHV = 32'h0000_0C00;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  chain_t chain_in = '0;
  logic [31:0] raise = '0;
  logic [31:0] service = '0;
  logic [31:0] irq_lines;
  logic fast_q, nrq, evi, er;
  logic [31:0] vec, rd;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Lines, chain request, fast, normal, vector
  row_t rows [11] = '{
    '{SEL, 1'b0, 1'b1, 1'b0, DEF}, '{32'h5, 1'b0, 1'b0, 1'b1, 32'h1000},
    '{32'h4000_0004, 1'b0, 1'b0, 1'b1, 32'h1010}, '{32'h4000_0000, 1'b0, 1'b0, 1'b1, 32'h10F0},
    '{32'h2, 1'b0, 1'b0, 1'b1, DEF}, '{32'h12, 1'b0, 1'b0, 1'b1, 32'h1020},
    '{32'h8000_0040, 1'b0, 1'b1, 1'b1, 32'h1030}, '{32'h0, 1'b1, 1'b0, 1'b1, CHV},
    '{32'h2, 1'b1, 1'b0, 1'b1, DEF}, '{32'h1, 1'b1, 1'b0, 1'b1, 32'h1000},
    '{32'h0, 1'b0, 1'b0, 1'b0, DEF}};
  // Clock
  always #25 clk = ~clk;
  vic_core u_vic_core (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .irq_lines(irq_lines), .chain_in(chain_in), .fast_interrupt_request(fast_q),
    .normal_interrupt_request(nrq), .vector_address(vec), .event_irq(evi));
  irq_source_model u_irq_source_model (.clk(clk), .rst_n(rst_n), .raise(raise),
    .service(service), .irq_lines(irq_lines));
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // No local limit: the hang guard ends a stuck wait
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Leave exactly the given lines high, then let them settle
  task automatic set_lines(input logic [31:0] v);
    raise <= v;
    service <= ~v;
    @(posedge clk);
    raise <= 32'h0;
    service <= 32'h0;
    repeat (5) @(posedge clk);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({29'h0, fast_q, nrq, evi}, 32'h0);
    rdchk(OFS_LINE_ENABLE, RST_WORD);
    rdchk(OFS_DEF_VECT, RST_WORD);
    apb(1'b1, OFS_LINE_ENABLE, 32'hFFFF_FFFF);
    apb(1'b1, OFS_LINE_SELECT, SEL);
    apb(1'b1, OFS_DEF_VECT, DEF);
    apb(1'b1, OFS_EV_MASK, 32'h2);
    for (int s = 0; s < NUM_SLOTS; s++) begin
      apb(1'b1, {PAGE_SLOT_ADDR, 8'(s * 4)}, 32'h1000 + 32'(s * 16));
      apb(1'b1, {PAGE_SLOT_CTRL, 8'(s * 4)}, (32'h1 << CTRL_EN_BIT) | 32'(s * 2));
    end
    rdchk({PAGE_SLOT_ADDR, 8'h3C}, 32'h10F0);
    for (int i = 0; i < 11; i++) begin
      chain_in <= '{req: rows[i].ch, vect: CHV};
      set_lines(rows[i].lines);
      chk({30'h0, fast_q, nrq}, {30'h0, rows[i].f, rows[i].n});
      chk(vec, rows[i].v);
      rdchk(OFS_VECT_NOW, rows[i].v);
      rdchk(OFS_RAW_STATUS, rows[i].lines);
      rdchk(OFS_FAST_STATUS, rows[i].lines & SEL);
    end
    // Event raise, read-clear, then mask
    apb(1'b0, OFS_EV_STATUS, 32'h0);
    set_lines(32'h2);
    chk({31'h0, evi}, 32'h1);
    rdchk(OFS_EV_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, evi}, 32'h0);
    apb(1'b1, OFS_EV_MASK, 32'h0);
    set_lines(32'h0);
    set_lines(32'h2);
    chk({31'h0, evi}, 32'h0);
    rdchk(OFS_EV_STATUS, 32'h2);
    // Disabled line stays raw only
    apb(1'b1, OFS_LINE_ENABLE, 32'hFFFF_FFFE);
    set_lines(32'h1);
    chk({31'h0, nrq}, 32'h0);
    rdchk(OFS_RAW_STATUS, 32'h1);
    rdchk(OFS_NORM_STATUS, 32'h0);
    // Unmapped address
    apb(1'b0, 12'h024, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // Reset in mid-run; the shared rst_n also clears line 0 in the source model
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({29'h0, fast_q, nrq, evi}, 32'h0);
    rdchk(OFS_LINE_ENABLE, RST_WORD);
    rdchk(OFS_RAW_STATUS, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
